/* hw/lpmsc_top.sv */
// Low-power module stop control: stop bits, protect gating, deep standby.
// Assumes a classic Wishbone master and a CPU halt strobe on entry.
// Assumes one clock; every input is synchronous to it.
// Assumes guarded registers elsewhere send write strobes through here.
// Assumes peripheral power switches follow the registered power outputs.
// Assumes software waits out clock settling around stop-bit rewrites.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Deep standby removes power from most units
// - Retained-stop units keep registers; flash retained
// - RTC runs in deep standby per control
// - Voltage detector, power-on reset, I/O hold stay
// - Register A bits halt timer W units
// - Register B bits halt serial channels
// - Register C bits halt serial ten, I2C two
// - Register D bits halt remote receiver, CAN FD
// - Wake enable holds period and alarm bits
// - Wake flags record period or alarm cause
// - Protect bit 0 gates clock registers
// - Protect bit 1 gates power mode registers
// - Protect bit 1 also gates mode, reset
// - Protect bit 3 gates voltage detector registers
// - Enter by register plus halt; leave by reset/interrupt
// - Deep standby cancelled by listed interrupts
module lpmsc_top
  import lpmsc_pkg::*;
(
  input  wire logic         ref_clk_in,
  input  wire logic         reset_n_in,
  input  wire logic         wb_cyc_in,
  input  wire logic         wb_stb_in,
  input  wire logic         wb_we_in,
  input  wire logic [7:0]   wb_adr_in,
  input  wire logic [3:0]   wb_sel_in,
  input  wire logic [31:0]  wb_dat_in,
  output logic      [31:0]  wb_dat_out,
  output logic              wb_ack_out,
  input  wire logic         cpu_halt_in,
  input  wire lpmsc_wake_s  wake_in,
  input  wire logic         clk_reg_wr_in,
  input  wire logic         volt_reg_wr_in,
  input  wire logic         mode_reg_wr_in,
  output logic              clk_reg_wr_ok_out,
  output logic              volt_reg_wr_ok_out,
  output logic              mode_reg_wr_ok_out,
  output lpmsc_power_s      power_out,
  output logic              wake_irq_out,
  output logic      [10:0]  clk_en_out
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Byte-lane merge of write data under a writable mask
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel,
                                             input logic [31:0] mask);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    lane_merge = (res & mask) | (old_v & ~mask);
  endfunction

  // Powered-down state decode, kept in one place
  function automatic logic is_deep(input lpmsc_state_e s);
    is_deep = (s == LPMSC_DEEP);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Registers and next values

  // One flip-flop and one next value per register
  logic [31:0]  mstp_a_ff;
  logic [31:0]  mstp_b_ff;
  logic [31:0]  mstp_c_ff;
  logic [31:0]  mstp_d_ff;
  logic [31:0]  nxt_mstp_a;
  logic [31:0]  nxt_mstp_b;
  logic [31:0]  nxt_mstp_c;
  logic [31:0]  nxt_mstp_d;
  logic [31:0]  wake_en_ff;
  logic [31:0]  nxt_wake_en;
  logic [31:0]  wake_fl_ff;
  logic [31:0]  nxt_wake_fl;
  logic [31:0]  protect_ff;
  logic [31:0]  nxt_protect;
  logic [31:0]  sby_ctl_ff;
  logic [31:0]  nxt_sby_ctl;
  logic [31:0]  rdata_ff;
  logic [31:0]  nxt_rdata;
  logic         ack_ff;
  logic         nxt_ack;
  lpmsc_state_e state_ff;
  lpmsc_state_e nxt_state;
  lpmsc_power_s power_ff;
  lpmsc_power_s nxt_power;

  // Decoded bus request, wake terms and state
  logic         req;
  logic         wr;
  logic         prot_pwr;
  logic         wake_any;
  logic         in_deep;
  logic [31:0]  rtc_events;

  // Request taken once; a standing ack blocks a second take
  assign req      = wb_cyc_in && wb_stb_in && !ack_ff;
  assign wr       = req && wb_we_in;
  assign prot_pwr = protect_ff[LPMSC_P_POWER];
  assign in_deep  = is_deep(state_ff);

  ////////////////////////////////////////////////////////////////////////
  // Write gating for guarded registers elsewhere in the chip

  // Pass a strobe only while its protect bit is set
  always_comb begin
    clk_reg_wr_ok_out  = clk_reg_wr_in  && protect_ff[LPMSC_P_CLOCK];
    mode_reg_wr_ok_out = mode_reg_wr_in && prot_pwr;
    volt_reg_wr_ok_out = volt_reg_wr_in && protect_ff[LPMSC_P_VOLT];
  end

  ////////////////////////////////////////////////////////////////////////
  // Wake sources

  // RTC events as flag vector, only those enabled
  always_comb begin
    rtc_events = '0;
    rtc_events[LPMSC_W_PERIOD] = wake_in.rtc_period && wake_en_ff[LPMSC_W_PERIOD];
    rtc_events[LPMSC_W_ALARM]  = wake_in.rtc_alarm  && wake_en_ff[LPMSC_W_ALARM];
    wake_any = wake_in.nmi || wake_in.ext_pin || wake_in.volt_mon1 ||
               wake_in.volt_mon2 || (|rtc_events);
  end

  ////////////////////////////////////////////////////////////////////////
  // Register file next values

  // Bus writes to power registers need protect bit 1
  always_comb begin
    nxt_mstp_a  = mstp_a_ff;
    nxt_mstp_b  = mstp_b_ff;
    nxt_mstp_c  = mstp_c_ff;
    nxt_mstp_d  = mstp_d_ff;
    nxt_wake_en = wake_en_ff;
    nxt_wake_fl = wake_fl_ff;
    nxt_protect = protect_ff;
    nxt_sby_ctl = sby_ctl_ff;
    if (wr) begin
      case (wb_adr_in)
        LPMSC_OFS_PROTECT: nxt_protect = lane_merge(protect_ff, wb_dat_in, wb_sel_in, LPMSC_MASK_P);
        default: begin
          if (prot_pwr) begin
            case (wb_adr_in)
              LPMSC_OFS_MSTP_A:  nxt_mstp_a  = lane_merge(mstp_a_ff, wb_dat_in, wb_sel_in, LPMSC_MASK_A);
              LPMSC_OFS_MSTP_B:  nxt_mstp_b  = lane_merge(mstp_b_ff, wb_dat_in, wb_sel_in, LPMSC_MASK_B);
              LPMSC_OFS_MSTP_C:  nxt_mstp_c  = lane_merge(mstp_c_ff, wb_dat_in, wb_sel_in, LPMSC_MASK_C);
              LPMSC_OFS_MSTP_D:  nxt_mstp_d  = lane_merge(mstp_d_ff, wb_dat_in, wb_sel_in, LPMSC_MASK_D);
              LPMSC_OFS_WAKE_EN: nxt_wake_en = lane_merge(wake_en_ff, wb_dat_in, wb_sel_in, LPMSC_MASK_W);
              LPMSC_OFS_SBY_CTL: nxt_sby_ctl = lane_merge(sby_ctl_ff, wb_dat_in, wb_sel_in, LPMSC_MASK_S);
              // Flags clear by writing zero to a set bit
              LPMSC_OFS_WAKE_FL: begin
                if (wb_sel_in[0]) begin
                  nxt_wake_fl = wake_fl_ff & (wb_dat_in | ~LPMSC_MASK_W);
                end
              end
              default: nxt_wake_fl = wake_fl_ff;
            endcase
          end
        end
      endcase
    end
    // Set wins over clear; record cause while in deep standby
    if (in_deep) begin
      nxt_wake_fl = nxt_wake_fl | rtc_events;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus answer

  // One-wait-state ack; unmapped reads give zero
  always_comb begin
    nxt_ack   = req;
    nxt_rdata = '0;
    if (req && !wb_we_in) begin
      case (wb_adr_in)
        LPMSC_OFS_MSTP_A:  nxt_rdata = mstp_a_ff;
        LPMSC_OFS_MSTP_B:  nxt_rdata = mstp_b_ff;
        LPMSC_OFS_MSTP_C:  nxt_rdata = mstp_c_ff;
        LPMSC_OFS_MSTP_D:  nxt_rdata = mstp_d_ff;
        LPMSC_OFS_WAKE_EN: nxt_rdata = wake_en_ff;
        LPMSC_OFS_WAKE_FL: nxt_rdata = wake_fl_ff;
        LPMSC_OFS_PROTECT: nxt_rdata = protect_ff;
        LPMSC_OFS_SBY_CTL: nxt_rdata = sby_ctl_ff;
        LPMSC_OFS_STATUS:  nxt_rdata = {30'h0000_0000, state_ff};
        default:           nxt_rdata = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power state machine

  // Enter on halt with deep bit set; leave on a wake source
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      LPMSC_RUN: begin
        if (cpu_halt_in && sby_ctl_ff[LPMSC_S_DEEP]) begin
          nxt_state = LPMSC_DEEP;
        end
      end
      LPMSC_DEEP: begin
        if (wake_any) begin
          nxt_state = LPMSC_WAKE;
        end
      end
      LPMSC_WAKE: nxt_state = LPMSC_RUN;
      default:    nxt_state = LPMSC_RUN;
    endcase
  end

  // Domain controls derived from the next state
  always_comb begin
    nxt_power              = '0;
    nxt_power.cpu_ram_off  = is_deep(nxt_state);
    nxt_power.wdt_off      = is_deep(nxt_state);
    nxt_power.periph_off   = is_deep(nxt_state);
    nxt_power.flash_retain = is_deep(nxt_state);
    nxt_power.rtc_run      = !is_deep(nxt_state) || sby_ctl_ff[LPMSC_S_RTC_RUN];
    nxt_power.volt_det_on  = 1'b1;
    nxt_power.por_on       = 1'b1;
    nxt_power.io_hold      = is_deep(nxt_state);
  end

  ////////////////////////////////////////////////////////////////////////
  // State registers

  // Registers only; all next-value logic lives above
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      mstp_a_ff  <= LPMSC_RST_MSTP & LPMSC_MASK_A;
      mstp_b_ff  <= LPMSC_RST_MSTP & LPMSC_MASK_B;
      mstp_c_ff  <= LPMSC_RST_MSTP & LPMSC_MASK_C;
      mstp_d_ff  <= LPMSC_RST_MSTP & LPMSC_MASK_D;
      wake_en_ff <= LPMSC_RST_ZERO;
      wake_fl_ff <= LPMSC_RST_ZERO;
      protect_ff <= LPMSC_RST_ZERO;
      sby_ctl_ff <= LPMSC_RST_ZERO;
      rdata_ff   <= LPMSC_RST_ZERO;
      ack_ff     <= 1'b0;
      state_ff   <= LPMSC_RUN;
      power_ff   <= '0;
    end else begin
      mstp_a_ff  <= nxt_mstp_a;
      mstp_b_ff  <= nxt_mstp_b;
      mstp_c_ff  <= nxt_mstp_c;
      mstp_d_ff  <= nxt_mstp_d;
      wake_en_ff <= nxt_wake_en;
      wake_fl_ff <= nxt_wake_fl;
      protect_ff <= nxt_protect;
      sby_ctl_ff <= nxt_sby_ctl;
      rdata_ff   <= nxt_rdata;
      ack_ff     <= nxt_ack;
      state_ff   <= nxt_state;
      power_ff   <= nxt_power;
    end
  end

  // Outputs straight from flip-flops, except the wake interrupt, decoded from the state
  assign wb_dat_out   = rdata_ff;
  assign wb_ack_out   = ack_ff;
  assign power_out    = power_ff;
  assign wake_irq_out = (state_ff == LPMSC_WAKE);

  ////////////////////////////////////////////////////////////////////////
  // Clock gates for stopped modules

  lpmsc_clock_gate u_gate (
    .ref_clk_in (ref_clk_in),
    .reset_n_in (reset_n_in),
    .mstp_a_in  (mstp_a_ff),
    .mstp_b_in  (mstp_b_ff),
    .mstp_c_in  (mstp_c_ff),
    .mstp_d_in  (mstp_d_ff),
    .deep_in    (power_ff.periph_off),
    .clk_en_out (clk_en_out)
  );

endmodule
`default_nettype wire

/* hw/lpmsc_pkg.sv */
// Package for the low-power module stop control block.
// Assumes a classic Wishbone slave with 32-bit data, byte addresses.
package lpmsc_pkg;

  // Register byte offsets
  localparam logic [7:0] LPMSC_OFS_MSTP_A  = 8'h00;
  localparam logic [7:0] LPMSC_OFS_MSTP_B  = 8'h04;
  localparam logic [7:0] LPMSC_OFS_MSTP_C  = 8'h08;
  localparam logic [7:0] LPMSC_OFS_MSTP_D  = 8'h0c;
  localparam logic [7:0] LPMSC_OFS_WAKE_EN = 8'h10;
  localparam logic [7:0] LPMSC_OFS_WAKE_FL = 8'h14;
  localparam logic [7:0] LPMSC_OFS_PROTECT = 8'h18;
  localparam logic [7:0] LPMSC_OFS_SBY_CTL = 8'h1c;
  localparam logic [7:0] LPMSC_OFS_STATUS  = 8'h20;

  // Module stop bit positions
  localparam int LPMSC_A_CMTW1   = 0;
  localparam int LPMSC_A_CMTW0   = 1;
  localparam int LPMSC_B_SER7    = 24;
  localparam int LPMSC_B_SER4    = 27;
  localparam int LPMSC_B_SER3    = 28;
  localparam int LPMSC_B_SER2    = 29;
  localparam int LPMSC_B_SER0    = 31;
  localparam int LPMSC_C_I2C2    = 17;
  localparam int LPMSC_C_SER10   = 25;
  localparam int LPMSC_D_REMOTE  = 7;
  localparam int LPMSC_D_CANFD   = 10;

  // Wake enable / flag bit positions
  localparam int LPMSC_W_PERIOD  = 0;
  localparam int LPMSC_W_ALARM   = 1;

  // Protect bit positions
  localparam int LPMSC_P_CLOCK   = 0;
  localparam int LPMSC_P_POWER   = 1;
  localparam int LPMSC_P_VOLT    = 3;

  // Standby control bit positions
  localparam int LPMSC_S_DEEP    = 0;
  localparam int LPMSC_S_RTC_RUN = 1;

  // Reset values
  localparam logic [31:0] LPMSC_RST_MSTP = 32'hffff_ffff;
  localparam logic [31:0] LPMSC_RST_ZERO = 32'h0000_0000;

  // Writable masks of implemented bits
  localparam logic [31:0] LPMSC_MASK_A = 32'h0000_0003;
  localparam logic [31:0] LPMSC_MASK_B = 32'hb900_0000;
  localparam logic [31:0] LPMSC_MASK_C = 32'h0202_0000;
  localparam logic [31:0] LPMSC_MASK_D = 32'h0000_0480;
  localparam logic [31:0] LPMSC_MASK_W = 32'h0000_0003;
  localparam logic [31:0] LPMSC_MASK_P = 32'h0000_000b;
  localparam logic [31:0] LPMSC_MASK_S = 32'h0000_0003;

  // Power states
  typedef enum logic [1:0] {
    LPMSC_RUN,
    LPMSC_DEEP,
    LPMSC_WAKE
  } lpmsc_state_e;

  // Wake sources from the outside
  typedef struct packed {
    logic nmi;
    logic ext_pin;
    logic volt_mon1;
    logic volt_mon2;
    logic rtc_period;
    logic rtc_alarm;
  } lpmsc_wake_s;

  // Power domain controls towards the chip
  typedef struct packed {
    logic cpu_ram_off;
    logic wdt_off;
    logic periph_off;
    logic flash_retain;
    logic rtc_run;
    logic volt_det_on;
    logic por_on;
    logic io_hold;
  } lpmsc_power_s;

endpackage

/* hw/lpmsc_clock_gate.sv */
// Per-module clock gate enables from the module stop bits.
// Assumes peripherals hold their registers while their enable is low.
`timescale 1ns/1ns
`default_nettype none
module lpmsc_clock_gate
  import lpmsc_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic [31:0] mstp_a_in,
  input  wire logic [31:0] mstp_b_in,
  input  wire logic [31:0] mstp_c_in,
  input  wire logic [31:0] mstp_d_in,
  input  wire logic        deep_in,
  output logic      [10:0] clk_en_out
);

  logic [10:0] clk_en_ff;
  logic [10:0] nxt_clk_en;

  // Stop bit set means clock off; deep standby stops all
  always_comb begin
    nxt_clk_en[0]  = ~mstp_a_in[LPMSC_A_CMTW1];
    nxt_clk_en[1]  = ~mstp_a_in[LPMSC_A_CMTW0];
    nxt_clk_en[2]  = ~mstp_b_in[LPMSC_B_SER7];
    nxt_clk_en[3]  = ~mstp_b_in[LPMSC_B_SER4];
    nxt_clk_en[4]  = ~mstp_b_in[LPMSC_B_SER3];
    nxt_clk_en[5]  = ~mstp_b_in[LPMSC_B_SER2];
    nxt_clk_en[6]  = ~mstp_b_in[LPMSC_B_SER0];
    nxt_clk_en[7]  = ~mstp_c_in[LPMSC_C_SER10];
    nxt_clk_en[8]  = ~mstp_c_in[LPMSC_C_I2C2];
    nxt_clk_en[9]  = ~mstp_d_in[LPMSC_D_REMOTE];
    nxt_clk_en[10] = ~mstp_d_in[LPMSC_D_CANFD];
    if (deep_in) begin
      nxt_clk_en = '0;
    end
  end

  // Gate enable register, glitch free towards clock gates
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      clk_en_ff <= '0;
    end else begin
      clk_en_ff <= nxt_clk_en;
    end
  end

  assign clk_en_out = clk_en_ff;

endmodule
`default_nettype wire

/* verification/lpmsc_props.sv */
// Checker for the low-power stop control top module.
// Assumes it is bound to lpmsc_top and sees that module's ports only.
`timescale 1ns/1ns
`default_nettype none
module lpmsc_props
  import lpmsc_pkg::*;
(
  input wire logic         ref_clk_in,
  input wire logic         reset_n_in,
  input wire logic         wb_cyc_in,
  input wire logic         wb_stb_in,
  input wire logic         wb_we_in,
  input wire logic [7:0]   wb_adr_in,
  input wire logic [3:0]   wb_sel_in,
  input wire logic [31:0]  wb_dat_in,
  input wire logic [31:0]  wb_dat_out,
  input wire logic         wb_ack_out,
  input wire logic         cpu_halt_in,
  input wire lpmsc_wake_s  wake_in,
  input wire logic         clk_reg_wr_in,
  input wire logic         volt_reg_wr_in,
  input wire logic         mode_reg_wr_in,
  input wire logic         clk_reg_wr_ok_out,
  input wire logic         volt_reg_wr_ok_out,
  input wire logic         mode_reg_wr_ok_out,
  input wire lpmsc_power_s power_out,
  input wire logic         wake_irq_out,
  input wire logic [10:0]  clk_en_out
);
  ////////////////////////////////////////////////////////////////////////////////
  logic [3:0] prot_ff;
  logic [3:0] nxt_prot;
  logic [1:0] sby_ff;
  logic [1:0] nxt_sby;
  logic       wr_take;

  // Mirror of protect and standby control from observed writes
  assign wr_take = wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out && wb_sel_in[0];
  always_comb begin
    nxt_prot = prot_ff;
    nxt_sby  = sby_ff;
    if (wr_take && wb_adr_in == LPMSC_OFS_PROTECT) nxt_prot = wb_dat_in[3:0] & 4'hb;
    if (wr_take && prot_ff[1] && wb_adr_in == LPMSC_OFS_SBY_CTL) nxt_sby = wb_dat_in[1:0];
  end
  always_ff @(posedge ref_clk_in) begin
    prot_ff <= reset_n_in ? nxt_prot : 4'h0;
    sby_ff  <= reset_n_in ? nxt_sby : 2'h0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);

  // Request taken and halt taken
  sequence taken_s;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence halt_s;
    cpu_halt_in && sby_ff[0] && !power_out.cpu_ram_off && !wake_irq_out;
  endsequence

  ack_timing_a: assert property (taken_s |=> wb_ack_out) else $error("ack missing");
  ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack too long");
  dat_idle_a: assert property (!wb_ack_out |-> wb_dat_out == 32'h0) else $error("data not idle");
  clk_gate_a: assert property (clk_reg_wr_ok_out == (clk_reg_wr_in && prot_ff[0])) else $error("clock gate");
  mode_gate_a: assert property (mode_reg_wr_ok_out == (mode_reg_wr_in && prot_ff[1])) else $error("mode gate");
  volt_gate_a: assert property (volt_reg_wr_ok_out == (volt_reg_wr_in && prot_ff[3])) else $error("volt gate");
  deep_entry_a: assert property (
    halt_s |=> power_out.cpu_ram_off && power_out.wdt_off && power_out.periph_off) else $error("no deep entry");
  halt_ignored_a: assert property (
    cpu_halt_in && !sby_ff[0] && !power_out.cpu_ram_off |=> !power_out.cpu_ram_off) else $error("halt not ignored");
  deep_hold_a: assert property (power_out.cpu_ram_off |-> power_out.por_on &&
    power_out.volt_det_on && power_out.io_hold && power_out.flash_retain && power_out.rtc_run == sby_ff[1])
    else $error("deep fields");
  stop_all_a: assert property ($rose(power_out.periph_off) |=> clk_en_out == 11'h0)
    else $error("clocks run in deep");
  wake_exit_a: assert property (
    power_out.cpu_ram_off && (wake_in.nmi || wake_in.ext_pin || wake_in.volt_mon1 || wake_in.volt_mon2)
    |=> !power_out.cpu_ram_off ##[0:1] wake_irq_out) else $error("no wake");
  irq_pulse_a: assert property (wake_irq_out |=> !wake_irq_out) else $error("irq too long");
endmodule

bind lpmsc_top lpmsc_props i_props (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .cpu_halt_in(cpu_halt_in), .wake_in(wake_in),
  .clk_reg_wr_in(clk_reg_wr_in), .volt_reg_wr_in(volt_reg_wr_in), .mode_reg_wr_in(mode_reg_wr_in),
  .clk_reg_wr_ok_out(clk_reg_wr_ok_out), .volt_reg_wr_ok_out(volt_reg_wr_ok_out),
  .mode_reg_wr_ok_out(mode_reg_wr_ok_out), .power_out(power_out), .wake_irq_out(wake_irq_out),
  .clk_en_out(clk_en_out));
`default_nettype wire

/* verification/tb.sv */
// Self-checking bench for the low-power stop control top module.
// Assumes the design answers Wishbone and drives power controls itself.
`timescale 1ns/1ns
`default_nettype none
module tb
  import lpmsc_pkg::*;
;
  logic         ref_clk_in, reset_n_in, cyc, stb, we, halt, ack, irq;
  logic [7:0]   adr;
  logic [3:0]   sel;
  logic [31:0]  wdat, rdat, dat_o, lfsr;
  logic [2:0]   wr_req, wr_ok;
  logic [10:0]  clk_en;
  lpmsc_wake_s  wake;
  lpmsc_power_s power;
  logic [31:0]  stop_v [4];
  logic [31:0]  mask_v [4] = '{LPMSC_MASK_A, LPMSC_MASK_B, LPMSC_MASK_C, LPMSC_MASK_D};
  logic [15:0]  runs [6] = '{16'hb081, 16'h7042, 16'h10e0, 16'h10d0, 16'h10c8, 16'h10c4};
  logic [7:0]   pw;
  int           fails, check_count, cycles, i, j, n;

  lpmsc_top i_dut (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(dat_o), .wb_ack_out(ack),
    .cpu_halt_in(halt), .wake_in(wake), .clk_reg_wr_in(wr_req[2]), .mode_reg_wr_in(wr_req[1]),
    .volt_reg_wr_in(wr_req[0]), .clk_reg_wr_ok_out(wr_ok[2]), .mode_reg_wr_ok_out(wr_ok[1]),
    .volt_reg_wr_ok_out(wr_ok[0]), .power_out(power), .wake_irq_out(irq), .clk_en_out(clk_en));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Running clocks are the inverse of the stop bits
  function automatic logic [10:0] exp_en(input logic [31:0] a, b, c, d);
    return ~{d[10], d[7], c[17], c[25], b[31], b[29], b[28], b[27], b[24], a[1], a[0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  // One classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    @(posedge ref_clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do begin
      @(posedge ref_clk_in);
    end while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask

  task automatic stop_test();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {reset_n_in, cyc, stb, we, halt, adr, wdat, wr_req} = '0;
    sel = 4'hf;
    wake = 6'h00;
    lfsr = 32'hc6ad;
    {fails, check_count} = '0;
    repeat (12) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    for (j = 0; j < 4; j++) rd_chk(8'(j * 4), mask_v[j]);
    rd_chk(LPMSC_OFS_WAKE_EN, 32'h0);
    rd_chk(8'h24, 32'h0);
    chk(clk_en, 11'h0);
    wb(1'b1, LPMSC_OFS_MSTP_B, 32'h0);
    rd_chk(LPMSC_OFS_MSTP_B, LPMSC_MASK_B);
    // Guarded strobes under random protect values
    for (i = 0; i < 12; i++) begin
      lfsr = lfsr_next(lfsr);
      wb(1'b1, LPMSC_OFS_PROTECT, (i == 11) ? 32'hff : lfsr);
      wr_req <= (i == 11) ? 3'h7 : lfsr[6:4];
      @(posedge ref_clk_in);
      chk(wr_ok, wr_req & ((i == 11) ? 3'h7 : {lfsr[0], lfsr[1], lfsr[3]}));
    end
    wr_req <= 3'h0;
    rd_chk(LPMSC_OFS_PROTECT, 32'hb);
    // Random stop patterns, all stopped first, all running last
    for (i = 0; i < 8; i++) begin
      for (j = 0; j < 4; j++) begin
        lfsr = lfsr_next(lfsr);
        stop_v[j] = (i == 0) ? 32'hffff_ffff : (i == 7) ? 32'h0 : lfsr;
        wb(1'b1, 8'(j * 4), stop_v[j]);
      end
      repeat (2) @(posedge ref_clk_in);
      chk(clk_en, exp_en(stop_v[0], stop_v[1], stop_v[2], stop_v[3]));
      for (j = 0; j < 4; j++) rd_chk(8'(j * 4), stop_v[j] & mask_v[j]);
    end
    // Byte lanes: register B stop bits live in the top lane only
    wb(1'b1, LPMSC_OFS_MSTP_B, 32'hffff_ffff, 4'h7);
    rd_chk(LPMSC_OFS_MSTP_B, 32'h0);
    wb(1'b1, LPMSC_OFS_MSTP_B, 32'hffff_ffff, 4'h8);
    rd_chk(LPMSC_OFS_MSTP_B, LPMSC_MASK_B);
    // Deep standby entry, decoy event, wake by each source
    for (i = 0; i < 6; i++) begin
      pw = runs[i][13] ? 8'hff : 8'hf7;
      wb(1'b1, LPMSC_OFS_WAKE_EN, {30'h0, runs[i][15:14]});
      wb(1'b1, LPMSC_OFS_SBY_CTL, {30'h0, runs[i][13:12]});
      repeat (2) @(posedge ref_clk_in);
      halt <= 1'b1;
      @(posedge ref_clk_in);
      halt <= 1'b0;
      repeat (3) @(posedge ref_clk_in);
      chk(power, pw);
      chk(clk_en, 11'h0);
      wake <= runs[i][11:6];
      @(posedge ref_clk_in);
      wake <= 6'h00;
      repeat (3) @(posedge ref_clk_in);
      chk(power, pw);
      wake <= runs[i][5:0];
      @(posedge ref_clk_in);
      wake <= 6'h00;
      for (n = 0; n < 10 && irq !== 1'b1; n++) @(posedge ref_clk_in);
      chk(irq, 1'b1);
      repeat (2) @(posedge ref_clk_in);
      chk(power, 8'h0e);
      rd_chk(LPMSC_OFS_STATUS, 32'h0);
      rd_chk(LPMSC_OFS_WAKE_FL, {30'h0, runs[i][0], runs[i][1]});
      wb(1'b1, LPMSC_OFS_WAKE_FL, 32'h0, 4'he);
      rd_chk(LPMSC_OFS_WAKE_FL, {30'h0, runs[i][0], runs[i][1]});
      wb(1'b1, LPMSC_OFS_WAKE_FL, 32'h0);
      rd_chk(LPMSC_OFS_WAKE_FL, 32'h0);
    end
    // Halt with deep bit clear is ignored
    wb(1'b1, LPMSC_OFS_SBY_CTL, 32'h0);
    halt <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    halt <= 1'b0;
    chk(power, 8'h0e);
    // Second reset in mid-run
    reset_n_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    rd_chk(LPMSC_OFS_PROTECT, 32'h0);
    rd_chk(LPMSC_OFS_MSTP_D, LPMSC_MASK_D);
    stop_test();
  end
endmodule
`default_nettype wire
